// file: bench/modem_host_status_flags_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module modem_host_status_flags_tb
  import modem_pkg::*;
;
  localparam int BC = 100;
  localparam int MC = 400;
  logic clk_sys, rst, bus_sel_n, bus_clk, bus_cmd, bus_reply_out, bus_reply_oe;
  logic interrupt_request_line_n, ring_node, call_progress_tone_seen, carrier_seen;
  logic answer_tone_seen, rx_mark_level, rx_dibit_valid, rx_parity_bad;
  logic tx_byte_valid, tx_byte_ready, oe;
  logic [1:0] rx_phase, tx_eq_route, rx_eq_route;
  logic [7:0] tx_byte_data, gain_setting, tx_mode_setting, rx_mode_setting, rd;
  int bad_count = 0;
  int compares = 0;

  modem_host_status_flags #(.BIT_CYC(BC), .MARK_CYC(MC)) i_dut (
    .clk_sys, .rst, .bus_sel_n, .bus_clk, .bus_cmd, .bus_reply_out, .bus_reply_oe,
    .interrupt_request_line_n, .ring_node, .call_progress_tone_seen, .carrier_seen,
    .answer_tone_seen, .rx_mark_level, .rx_dibit_valid, .rx_phase, .rx_parity_bad,
    .tx_byte_data, .tx_byte_valid, .tx_byte_ready, .gain_setting, .tx_mode_setting,
    .rx_mode_setting, .tx_eq_route, .rx_eq_route);
  serial_host i_host (.clk_sys, .bus_sel_n, .bus_clk, .bus_cmd, .bus_reply_out,
    .bus_reply_oe);

  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;

  // ****************************************
  // helpers
  // ****************************************
  task automatic final_report();
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.xfer(a, d, rd, oe);
  endtask
  task automatic rdr(input logic [7:0] a);
    i_host.xfer(a, 8'h00, rd, oe);
  endtask
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (interrupt_request_line_n !== 1'b0) begin
      cyc(1);
      n++;
      if (n > lim) begin
        `CHK(interrupt_request_line_n, 1'b0)
        final_report();
      end
    end
  endtask
  task automatic dibit(input logic [1:0] p);
    rx_dibit_valid = 1'b1;
    rx_phase = p;
    cyc(1);
    rx_dibit_valid = 1'b0;
    cyc(3);
  endtask
  // phases 90, 0, 270, 180 pack to 00 01 11 10
  task automatic send_byte(input logic bad);
    rx_parity_bad = bad;
    dibit(PH_90);
    dibit(PH_0);
    dibit(PH_270);
    dibit(PH_180);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rdr(EVENT_FLAGS_ADDR);
    `CHK(rd, REG_RESET)
    rdr(SIGNALLING_STATUS_ADDR);
    `CHK(rd, REG_RESET)
    `CHK(interrupt_request_line_n, 1'b1)
    `CHK(tx_eq_route, EQ_BYPASS)
    rdr(8'h55);
    `CHK(oe, 1'b0)
    wr(GAIN_CONFIG_ADDR, 8'h5A);
    `CHK(gain_setting, 8'h5A)
  endtask
  task automatic t_rx();
    wr(EVENT_MASK_ADDR, 8'h08);
    wr(RX_DEMOD_CONFIG_ADDR, 8'h02);
    rdr(EVENT_FLAGS_ADDR);
    send_byte(1'b1);
    wait_irq(20);
    rdr(EVENT_FLAGS_ADDR);
    `CHK(rd, 8'h88)
    `CHK(interrupt_request_line_n, 1'b1)
    rdr(RX_BYTE_BUFFER_ADDR);
    `CHK(rd, 8'h1E)
    rdr(EVENT_FLAGS_ADDR);
    `CHK(rd, 8'h00)
  endtask
  task automatic t_overrun();
    wr(EVENT_MASK_ADDR, 8'h10);
    send_byte(1'b0);
    cyc(6 * BC);
    `CHK(interrupt_request_line_n, 1'b1)
    wait_irq(3 * BC);
    rdr(EVENT_FLAGS_ADDR);
    `CHK(rd, 8'h18)
    rdr(RX_BYTE_BUFFER_ADDR);
    `CHK(rd, 8'h1E)
  endtask
  task automatic t_status();
    logic [7:0] e [4] = '{8'h00, 8'h20, 8'h10, 8'h08};
    wr(RX_DEMOD_CONFIG_ADDR, 8'h00);
    {call_progress_tone_seen, carrier_seen, answer_tone_seen} = 3'b111;
    rdr(EVENT_FLAGS_ADDR);
    ring_node = 1'b1;
    cyc(10);
    rdr(EVENT_FLAGS_ADDR);
    `CHK(rd, 8'h40)
    for (int c = 0; c < 4; c++) begin
      wr(SETUP_CONFIG_ADDR, 8'(c << DET_SEL_LO_BIT));
      rdr(SIGNALLING_STATUS_ADDR);
      `CHK(rd, 8'h40)
      wr(RX_DEMOD_CONFIG_ADDR, 8'h02);
      rdr(SIGNALLING_STATUS_ADDR);
      `CHK(rd, 8'h40 | e[c])
      wr(RX_DEMOD_CONFIG_ADDR, 8'h00);
    end
    rdr(EVENT_FLAGS_ADDR);
    `CHK(rd, 8'h20)
    ring_node = 1'b0;
    wr(SETUP_CONFIG_ADDR, 8'h00);
    rdr(EVENT_FLAGS_ADDR);
    `CHK(rd, 8'h40)
  endtask
  task automatic t_mark();
    wr(RX_DEMOD_CONFIG_ADDR, 8'h02);
    rdr(EVENT_FLAGS_ADDR);
    rx_mark_level = 1'b1;
    cyc(MC / 2);
    rdr(SIGNALLING_STATUS_ADDR);
    `CHK(rd, 8'h00)
    cyc(MC);
    rdr(SIGNALLING_STATUS_ADDR);
    `CHK(rd, 8'h01)
    rdr(EVENT_FLAGS_ADDR);
    `CHK(rd, 8'h01)
    rx_mark_level = 1'b0;
  endtask
  task automatic t_tx();
    for (int i = 0; i < 9; i++) begin
      wr(TX_BYTE_BUFFER_ADDR, 8'(8'hA0 + i));
    end
    rdr(EVENT_FLAGS_ADDR);
    wr(EVENT_MASK_ADDR, 8'h06);
    wr(TX_MODULATOR_CONFIG_ADDR, 8'h02);
    for (int i = 0; i < 8; i++) begin
      `CHK(tx_byte_valid, 1'b1)
      `CHK(tx_byte_data, 8'(8'hA0 + i))
      tx_byte_ready = 1'b1;
      cyc(1);
      tx_byte_ready = 1'b0;
      cyc(5);
    end
    `CHK(tx_byte_valid, 1'b0)
    wait_irq(20);
    rdr(EVENT_FLAGS_ADDR);
    `CHK(rd[2:1], 2'b01)
    wait_irq(9 * BC);
    rdr(EVENT_FLAGS_ADDR);
    `CHK(rd[2:1], 2'b10)
  endtask
  task automatic t_eq();
    for (int b = 0; b < 4; b++) begin
      wr(TX_MODULATOR_CONFIG_ADDR, {7'h01, b[0]});
      wr(RX_DEMOD_CONFIG_ADDR, {7'h01, b[1]});
      cyc(4);
      `CHK(tx_mode_setting, {7'h01, b[0]})
      `CHK(rx_mode_setting, {7'h01, b[1]})
      `CHK(tx_eq_route, (b[0] == b[1]) ? EQ_BYPASS : (b[0] ? EQ_HIGH : EQ_LOW))
      `CHK(rx_eq_route, (b[0] == b[1]) ? EQ_BYPASS : (b[1] ? EQ_HIGH : EQ_LOW))
    end
  endtask

  initial begin
    rst = 1'b1;
    {ring_node, call_progress_tone_seen, carrier_seen, answer_tone_seen} = 4'h0;
    {rx_mark_level, rx_dibit_valid, rx_parity_bad, tx_byte_ready} = 4'h0;
    rx_phase = PH_0;
    cyc(16);
    rst = 1'b0;
    cyc(4);
    t_reset();
    t_rx();
    t_overrun();
    t_status();
    t_mark();
    t_tx();
    t_eq();
    final_report();
  end
endmodule
`default_nettype wire

// file: bench/serial_host.sv
`timescale 1ns/100ps
`default_nettype none
module serial_host (
  input wire logic clk_sys, // system clock
  output logic bus_sel_n, // select, low active
  output logic bus_clk, // bus clock
  output logic bus_cmd, // command data
  input wire logic bus_reply_out, // reply data
  input wire logic bus_reply_oe // reply enable
);
  // ****************************************
  // frame driver
  // ****************************************
  initial begin
    bus_sel_n = 1'b1;
    bus_clk = 1'b0;
    bus_cmd = 1'b0;
  end

  task automatic half();
    repeat (4) @(negedge clk_sys);
  endtask

  // bus clock runs only inside a frame; reply sampled just before each of the last eight rises
  // an undriven reply line floats high on its pull-up
  task automatic xfer(input logic [7:0] a, input logic [7:0] w, output logic [7:0] r,
                      output logic oe);
    logic [15:0] s;
    s = {a, w};
    r = 8'h00;
    oe = 1'b0;
    @(negedge clk_sys);
    bus_sel_n = 1'b0;
    half();
    for (int i = 15; i >= 0; i--) begin
      bus_cmd = s[i];
      half();
      if (i < 8) begin
        r = {r[6:0], bus_reply_oe ? bus_reply_out : 1'b1};
        oe = oe | bus_reply_oe;
      end
      bus_clk = 1'b1;
      half();
      bus_clk = 1'b0;
    end
    half();
    bus_sel_n = 1'b1;
    bus_cmd = ~bus_cmd;
    half();
  endtask
endmodule
`default_nettype wire

// file: common/modem_pkg.sv
`default_nettype none
package modem_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int BIT_PERIOD_NS = 833333;
  localparam int BIT_CYCLES = BIT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int MARK_TIME_MS = 160;
  localparam int MARK_CYCLES = (MARK_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int WINDOW_BITS = 8;
  localparam int DIBITS_PER_BYTE = 4;
  localparam int TX_FIFO_DEPTH = 8;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] SETUP_CONFIG_ADDR = 8'hE0;
  localparam logic [7:0] GAIN_CONFIG_ADDR = 8'hE2;
  localparam logic [7:0] TX_BYTE_BUFFER_ADDR = 8'hE3;
  localparam logic [7:0] TX_MODULATOR_CONFIG_ADDR = 8'hE7;
  localparam logic [7:0] RX_DEMOD_CONFIG_ADDR = 8'hE8;
  localparam logic [7:0] RX_BYTE_BUFFER_ADDR = 8'hEA;
  localparam logic [7:0] SIGNALLING_STATUS_ADDR = 8'hEC;
  localparam logic [7:0] EVENT_MASK_ADDR = 8'hEE;
  localparam logic [7:0] EVENT_FLAGS_ADDR = 8'hEF;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int CFG_ENABLE_BIT = 1;
  localparam int CFG_BAND_BIT = 0;
  localparam int DET_SEL_LO_BIT = 4;
  localparam int ST_RING_BIT = 6;
  localparam int ST_CALL_BIT = 5;
  localparam int ST_CARRIER_BIT = 4;
  localparam int ST_ANSWER_BIT = 3;
  localparam int ST_MARK_BIT = 0;
  localparam logic [7:0] REG_RESET = 8'h00;

  // detector select codes
  localparam logic [1:0] DET_NONE = 2'h0;
  localparam logic [1:0] DET_CALL = 2'h1;
  localparam logic [1:0] DET_CARRIER = 2'h2;
  localparam logic [1:0] DET_ANSWER = 2'h3;

  // equaliser routes
  localparam logic [1:0] EQ_BYPASS = 2'h0;
  localparam logic [1:0] EQ_LOW = 2'h1;
  localparam logic [1:0] EQ_HIGH = 2'h2;

  // phase change codes from the demodulator
  localparam logic [1:0] PH_0 = 2'h0;
  localparam logic [1:0] PH_90 = 2'h1;
  localparam logic [1:0] PH_180 = 2'h2;
  localparam logic [1:0] PH_270 = 2'h3;

endpackage
`default_nettype wire

// file: rtl/modem_host_status_flags.sv
`timescale 1ns/100ps
`default_nettype none
module modem_host_status_flags
  import modem_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYCLES,
  parameter int MARK_CYC = MARK_CYCLES
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // synchronous reset
  input wire logic bus_sel_n, // serial bus select, low active
  input wire logic bus_clk, // serial bus clock
  input wire logic bus_cmd, // serial command data in
  output logic bus_reply_out, // serial reply data
  output logic bus_reply_oe, // reply driver enable
  output logic interrupt_request_line_n, // interrupt, low active
  input wire logic ring_node, // ring/reversal sense, async
  input wire logic call_progress_tone_seen, // raw call progress detector
  input wire logic carrier_seen, // raw carrier detector
  input wire logic answer_tone_seen, // raw answer tone detector
  input wire logic rx_mark_level, // unscrambled one on received data
  input wire logic rx_dibit_valid, // phase change strobe
  input wire logic [1:0] rx_phase, // phase change code
  input wire logic rx_parity_bad, // parity of current char wrong
  output logic [7:0] tx_byte_data, // byte to modulator
  output logic tx_byte_valid, // byte available to modulator
  input wire logic tx_byte_ready, // modulator takes byte
  output logic [7:0] gain_setting, // gain block setting
  output logic [7:0] tx_mode_setting, // modulator configuration
  output logic [7:0] rx_mode_setting, // demodulator configuration
  output logic [1:0] tx_eq_route, // transmit equaliser route
  output logic [1:0] rx_eq_route // receive equaliser route
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [1:0] phase_to_dibit(input logic [1:0] ph);
    logic [1:0] d;
    d = 2'h0;
    unique case (ph)
      PH_90: d = 2'h0;
      PH_0: d = 2'h1;
      PH_270: d = 2'h3;
      PH_180: d = 2'h2;
    endcase
    return d;
  endfunction

  function automatic logic [1:0] eq_route(input logic band, input logic other);
    return (band == other) ? EQ_BYPASS : (band ? EQ_HIGH : EQ_LOW);
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] sel_sync_reg;
  logic [2:0] sclk_sync_reg;
  logic [1:0] cmd_sync_reg;
  logic [1:0] ring_sync_reg;
  logic sel_act;
  logic sclk_rise;
  logic sclk_fall;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sel_sync_reg <= 2'h3;
      sclk_sync_reg <= 3'h0;
      cmd_sync_reg <= 2'h0;
      ring_sync_reg <= 2'h0;
    end else begin
      sel_sync_reg <= {sel_sync_reg[0], bus_sel_n};
      sclk_sync_reg <= {sclk_sync_reg[1:0], bus_clk};
      cmd_sync_reg <= {cmd_sync_reg[0], bus_cmd};
      ring_sync_reg <= {ring_sync_reg[0], ring_node};
    end
  end

  assign sel_act = ~sel_sync_reg[1];
  assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];

  // ****************************************
  // configuration registers
  // ****************************************
  logic [7:0] setup_config_reg;
  logic [7:0] gain_config_reg;
  logic [7:0] tx_modulator_config_reg;
  logic [7:0] rx_demod_config_reg;
  logic [7:0] event_mask_reg;
  logic [7:0] event_flags_reg;
  logic [7:0] status_reg;
  logic [7:0] rx_byte_buffer_reg;
  logic wr_strobe;
  logic rd_strobe;
  logic [7:0] bus_addr_reg;
  logic [7:0] bus_data;
  logic rx_en;
  logic tx_en;
  logic [1:0] det_sel;

  assign rx_en = rx_demod_config_reg[CFG_ENABLE_BIT];
  assign tx_en = tx_modulator_config_reg[CFG_ENABLE_BIT];
  assign det_sel = setup_config_reg[DET_SEL_LO_BIT +: 2];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      setup_config_reg <= REG_RESET;
      gain_config_reg <= REG_RESET;
      tx_modulator_config_reg <= REG_RESET;
      rx_demod_config_reg <= REG_RESET;
      event_mask_reg <= REG_RESET;
    end else if (wr_strobe) begin
      unique case (bus_addr_reg)
        SETUP_CONFIG_ADDR: setup_config_reg <= bus_data;
        GAIN_CONFIG_ADDR: gain_config_reg <= bus_data;
        TX_MODULATOR_CONFIG_ADDR: tx_modulator_config_reg <= bus_data;
        RX_DEMOD_CONFIG_ADDR: rx_demod_config_reg <= bus_data;
        EVENT_MASK_ADDR: event_mask_reg <= bus_data;
        default: ;
      endcase
    end
  end

  // ****************************************
  // serial bus slave
  // ****************************************
  logic [3:0] bit_cnt_reg;
  logic [7:0] cmd_shift_reg;
  logic [7:0] reply_shift_reg;
  logic reading_reg;
  logic addr_done;
  logic is_read_addr;
  logic [7:0] read_value;
  logic [7:0] addr_next;

  assign addr_next = {cmd_shift_reg[6:0], cmd_sync_reg[1]};
  assign bus_data = addr_next;
  assign addr_done = sel_act & sclk_rise & (bit_cnt_reg == 4'h7);
  assign wr_strobe = sel_act & sclk_rise & (bit_cnt_reg == 4'hF) & ~reading_reg;
  assign is_read_addr = (addr_next == RX_BYTE_BUFFER_ADDR) ||
                        (addr_next == SIGNALLING_STATUS_ADDR) ||
                        (addr_next == EVENT_FLAGS_ADDR);
  assign rd_strobe = addr_done & is_read_addr;

  always_comb begin
    read_value = REG_RESET;
    unique case (addr_next)
      RX_BYTE_BUFFER_ADDR: read_value = rx_byte_buffer_reg;
      SIGNALLING_STATUS_ADDR: read_value = status_reg;
      EVENT_FLAGS_ADDR: read_value = event_flags_reg;
      default: read_value = REG_RESET;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst || !sel_act) begin
      bit_cnt_reg <= 4'h0;
      cmd_shift_reg <= 8'h00;
      reading_reg <= 1'b0;
      reply_shift_reg <= 8'h00;
      bus_reply_out <= 1'b0;
    end else begin
      if (sclk_rise) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        cmd_shift_reg <= addr_next;
      end
      if (addr_done) begin
        bus_addr_reg <= addr_next;
        reading_reg <= is_read_addr;
        reply_shift_reg <= read_value;
      end
      if (sclk_fall && reading_reg) begin
        bus_reply_out <= reply_shift_reg[7];
        reply_shift_reg <= {reply_shift_reg[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_reply_oe <= 1'b0;
    end else begin
      bus_reply_oe <= sel_act & (reading_reg | rd_strobe);
    end
  end

  // ****************************************
  // bit period divider
  // ****************************************
  logic [15:0] div_reg;
  logic bit_tick;

  assign bit_tick = (div_reg == 16'(BIT_CYC - 1));

  always_ff @(posedge clk_sys) begin
    if (rst || bit_tick) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  // ****************************************
  // receive byte assembly
  // ****************************************
  logic [5:0] rx_shift_reg;
  logic [1:0] dibit_cnt_reg;
  logic byte_done;
  logic rx_unread_reg;
  logic [3:0] rx_win_reg;
  logic rx_overrun;

  assign byte_done = rx_en & rx_dibit_valid & (dibit_cnt_reg == 2'(DIBITS_PER_BYTE - 1));
  assign rx_overrun = rx_unread_reg & bit_tick & (rx_win_reg == 4'(WINDOW_BITS - 1));

  always_ff @(posedge clk_sys) begin
    if (rst || !rx_en) begin
      rx_shift_reg <= 6'h00;
      dibit_cnt_reg <= 2'h0;
    end else if (rx_dibit_valid) begin
      rx_shift_reg <= {rx_shift_reg[3:0], phase_to_dibit(rx_phase)};
      dibit_cnt_reg <= dibit_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_byte_buffer_reg <= REG_RESET;
    end else if (byte_done) begin
      rx_byte_buffer_reg <= {rx_shift_reg, phase_to_dibit(rx_phase)};
    end
  end

  // read window counts free-running bit divider ticks from the ready flag, so its first period can be partial
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_unread_reg <= 1'b0;
      rx_win_reg <= 4'h0;
    end else if (byte_done) begin
      rx_unread_reg <= 1'b1;
      rx_win_reg <= 4'h0;
    end else if (rd_strobe && addr_next == RX_BYTE_BUFFER_ADDR) begin
      rx_unread_reg <= 1'b0;
    end else if (rx_overrun) begin
      rx_unread_reg <= 1'b0;
    end else if (rx_unread_reg && bit_tick) begin
      rx_win_reg <= rx_win_reg + 4'h1;
    end
  end

  // ****************************************
  // signalling status
  // ****************************************
  logic [23:0] mark_cnt_reg;
  logic mark_full;
  logic [7:0] status_next;

  assign mark_full = (mark_cnt_reg == 24'(MARK_CYC));

  always_ff @(posedge clk_sys) begin
    if (rst || !rx_en || !rx_mark_level) begin
      mark_cnt_reg <= 24'h000000;
    end else if (!mark_full) begin
      mark_cnt_reg <= mark_cnt_reg + 24'h000001;
    end
  end

  always_comb begin
    status_next = REG_RESET;
    status_next[ST_RING_BIT] = ring_sync_reg[1];
    status_next[ST_CALL_BIT] = rx_en & (det_sel == DET_CALL) & call_progress_tone_seen;
    status_next[ST_CARRIER_BIT] = rx_en & (det_sel == DET_CARRIER) & carrier_seen;
    status_next[ST_ANSWER_BIT] = rx_en & (det_sel == DET_ANSWER) & answer_tone_seen;
    status_next[ST_MARK_BIT] = rx_en & mark_full;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_reg <= REG_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // ****************************************
  // transmit buffer
  // ****************************************
  logic tx_in_ready;
  logic tx_load;
  logic tx_pop;
  logic tx_wait_reg;
  logic [3:0] tx_win_reg;
  logic tx_underrun;

  assign tx_load = wr_strobe & (bus_addr_reg == TX_BYTE_BUFFER_ADDR);
  assign tx_pop = tx_byte_valid & tx_byte_ready;
  assign tx_underrun = tx_wait_reg & bit_tick & (tx_win_reg == 4'(WINDOW_BITS - 1));

  tx_fifo #(
    .WIDTH(8),
    .DEPTH(TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_data(bus_data),
    .in_valid(tx_load),
    .in_ready(tx_in_ready),
    .out_data(tx_byte_data),
    .out_valid(tx_byte_valid),
    .out_ready(tx_byte_ready & tx_en)
  );

  always_ff @(posedge clk_sys) begin
    if (rst || !tx_en) begin
      tx_wait_reg <= 1'b0;
      tx_win_reg <= 4'h0;
    end else if (tx_pop) begin
      tx_wait_reg <= 1'b1;
      tx_win_reg <= 4'h0;
    end else if (tx_load || tx_underrun) begin
      tx_wait_reg <= 1'b0;
    end else if (tx_wait_reg && bit_tick) begin
      tx_win_reg <= tx_win_reg + 4'h1;
    end
  end

  // ****************************************
  // event flags and interrupt
  // ****************************************
  logic [7:0] ev;

  always_comb begin
    ev = 8'h00;
    ev[7] = byte_done & rx_parity_bad;
    ev[6] = status_next[ST_RING_BIT] ^ status_reg[ST_RING_BIT];
    ev[5] = |(status_next[ST_CALL_BIT:ST_ANSWER_BIT] ^ status_reg[ST_CALL_BIT:ST_ANSWER_BIT]);
    ev[4] = rx_overrun;
    ev[3] = byte_done;
    ev[2] = tx_underrun & tx_en;
    ev[1] = tx_pop & tx_en;
    ev[0] = status_next[ST_MARK_BIT] ^ status_reg[ST_MARK_BIT];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      event_flags_reg <= REG_RESET;
    end else if (rd_strobe && addr_next == EVENT_FLAGS_ADDR) begin
      event_flags_reg <= ev;
    end else begin
      event_flags_reg <= event_flags_reg | ev;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      interrupt_request_line_n <= 1'b1;
    end else begin
      interrupt_request_line_n <= ~|(event_flags_reg & event_mask_reg);
    end
  end

  // ****************************************
  // outputs and equaliser routing
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_eq_route <= EQ_BYPASS;
      rx_eq_route <= EQ_BYPASS;
    end else begin
      tx_eq_route <= eq_route(tx_modulator_config_reg[CFG_BAND_BIT],
                              rx_demod_config_reg[CFG_BAND_BIT]);
      rx_eq_route <= eq_route(rx_demod_config_reg[CFG_BAND_BIT],
                              tx_modulator_config_reg[CFG_BAND_BIT]);
    end
  end

  assign gain_setting = gain_config_reg;
  assign tx_mode_setting = tx_modulator_config_reg;
  assign rx_mode_setting = rx_demod_config_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_RX_LOAD: assert property (byte_done |=> event_flags_reg[3] && rx_unread_reg && rx_win_reg == 4'h0) else $error("rx byte load without ready flag");
  AST_DIBIT_MSB: assert property (byte_done |=> rx_byte_buffer_reg[7:6] == $past(rx_shift_reg[5:4])) else $error("first dibit not in top bits");
  AST_DIBIT_MAP: assert property (rx_en && rx_dibit_valid && rx_phase == PH_90 |=> rx_shift_reg[1:0] == 2'h0 || $past(byte_done)) else $error("phase 90 not 00");
  AST_RING: assert property (1'b1 |=> status_reg[ST_RING_BIT] == $past(ring_sync_reg[1])) else $error("ring status not mirrored");
  AST_EXCL: assert property ($onehot0(status_reg[ST_CALL_BIT:ST_ANSWER_BIT])) else $error("detector bits not exclusive");
  AST_RX_GATE: assert property (!rx_en |=> status_reg[5:0] == 6'h00) else $error("detection while receiver off");
  AST_IRQ: assert property (|(event_flags_reg & event_mask_reg) |=> !interrupt_request_line_n) else $error("masked flag missed interrupt");
  AST_CLR: assert property (rd_strobe && addr_next == EVENT_FLAGS_ADDR && ev == 8'h00 |=> event_flags_reg == 8'h00) else $error("flags not cleared on read");
  AST_SETWIN: assert property (ev[3] |=> event_flags_reg[3]) else $error("event lost");
  AST_EQ: assert property (##1 tx_modulator_config_reg[0] == rx_demod_config_reg[0] && $stable(tx_modulator_config_reg) && $stable(rx_demod_config_reg) |=> tx_eq_route == EQ_BYPASS) else $error("equaliser not bypassed");

  COV_RX_BYTE: cover property (byte_done ##[1:200] rd_strobe);
  COV_OVERRUN: cover property (rx_overrun);
  COV_UNDERRUN: cover property (tx_underrun);
  COV_IRQ: cover property ($fell(interrupt_request_line_n));

endmodule
`default_nettype wire

// file: rtl/tx_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // synchronous reset
  input wire logic [WIDTH-1:0] in_data, // write data
  input wire logic in_valid, // write request
  output logic in_ready, // space available
  output logic [WIDTH-1:0] out_data, // head word
  output logic out_valid, // word available
  input wire logic out_ready // consumer takes word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire
